// ### mpw_pkg.sv
// Constants for the match based pulse width timer.
// Assumes a 100 MHz clock and an Avalon-MM slave with byte addressing.
package mpw_pkg;
  localparam int MPW_W      = 32;
  localparam int MPW_NMATCH = 7;
  localparam int MPW_NOUT   = 6;
  localparam int MPW_AW     = 6;

  // Register byte offsets
  localparam logic [5:0] MPW_OFS_CTRL  = 6'h00;
  localparam logic [5:0] MPW_OFS_COUNT = 6'h04;
  localparam logic [5:0] MPW_OFS_PRE   = 6'h08;
  localparam logic [5:0] MPW_OFS_PCNT  = 6'h0C;
  localparam logic [5:0] MPW_OFS_MACT  = 6'h10;
  localparam logic [5:0] MPW_OFS_FLAG  = 6'h14;
  localparam logic [5:0] MPW_OFS_OCFG  = 6'h18;
  localparam logic [5:0] MPW_OFS_REL   = 6'h1C;
  localparam logic [5:0] MPW_OFS_MBASE = 6'h20;
  localparam logic [5:0] MPW_OFS_MLAST = 6'h38;

  // Control register fields
  localparam int MPW_CTRL_EN  = 0;
  localparam int MPW_CTRL_RST = 1;
  localparam int MPW_CTRL_PWM = 3;

  // Match action fields, three bits per match
  localparam int MPW_MACT_STRIDE = 3;
  localparam int MPW_MACT_INT    = 0;
  localparam int MPW_MACT_RESET  = 1;
  localparam int MPW_MACT_STOP   = 2;
  localparam int MPW_MACT_BITS   = 21;

  // Output configuration: double-edge select and output enables
  localparam int MPW_OCFG_SEL = 1;
  localparam int MPW_OCFG_ENA = 9;

  localparam logic [31:0] MPW_ZERO32 = 32'h0000_0000;
  localparam logic [31:0] MPW_ONE32  = 32'h0000_0001;
endpackage

// ### mpw_chan.sv
// One pulse output channel of the match based pulse width timer.
// Assumes set and clear strobes are one-cycle match events.
`timescale 1ns/1ns
module mpw_chan
  import mpw_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic enable,
  input  wire logic dbl,
  input  wire logic cyc_match,
  input  wire logic rise_match,
  input  wire logic fall_match,
  output logic      pwm_out
);
  logic set_ev;

  // Single edge rises at the cycle match, double edge at its rise match
  assign set_ev = dbl ? rise_match : cyc_match;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_out <= 1'b0;
    end else if (clk_en) begin
      if (!enable) begin
        pwm_out <= 1'b0;
      end else if (fall_match) begin
        // Clear wins, so in single edge a fall on the cycle match gives a constant low
        pwm_out <= 1'b0;
      end else if (set_ev) begin
        pwm_out <= 1'b1;
      end
    end
  end

  chk_fall_edge: assert property (@(posedge clk) disable iff (rst)
    (clk_en && fall_match) |=> !pwm_out) else $error("output not low after fall match");
  chk_rise_edge: assert property (@(posedge clk) disable iff (rst)
    (clk_en && enable && set_ev && !fall_match) |=> pwm_out)
    else $error("output not high after rise event");
  chk_held_off: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !enable) |=> !pwm_out) else $error("disabled output not low");
endmodule

// ### mpw_timer.sv
// Match based pulse width timer: 32-bit counter, prescaler, seven matches.
// Assumes one 100 MHz clock, async high reset and an Avalon-MM master.
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
module mpw_timer
  import mpw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic [6:1]       pwm_out
);
  logic [31:0] count;
  logic [31:0] pre;
  logic [31:0] pcnt;
  logic        cnt_en;
  logic        cnt_rst;
  logic        pwm_mode;
  logic [20:0] mact;
  logic [6:0]  flag;
  logic [6:0]  rel;
  logic [6:1]  dbl_sel;
  logic [6:1]  out_ena;
  logic [31:0] shadow [MPW_NMATCH];
  logic [31:0] active [MPW_NMATCH];

  logic        req;
  logic        wr_go;
  logic        tick;
  logic [6:0]  match;
  logic [6:0]  rst_mask;
  logic [6:0]  stop_mask;
  logic [6:0]  int_mask;
  logic        any_reset;
  logic        any_stop;
  logic        cycle_end;
  logic [2:0]  wr_idx;
  logic        wr_ism;
  logic [2:0]  rd_idx;
  logic        rd_ism;
  logic [31:0] ctrl_rd;
  logic [31:0] mact_wd;

  // Merges write data into a register under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Decodes an address in the match window to its index
  function automatic logic [3:0] match_dec(input logic [5:0] a);
    logic [5:0] d;
    d = a - MPW_OFS_MBASE;
    if (a >= MPW_OFS_MBASE && a <= MPW_OFS_MLAST && a[1:0] == 2'b00) begin
      return {1'b1, d[4:2]};
    end
    return 4'h0;
  endfunction

  // Picks one action bit per match from the action register
  function automatic logic [6:0] mact_field(input logic [20:0] m, input int f);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 0; i < MPW_NMATCH; i++) begin
      r[i] = m[i*MPW_MACT_STRIDE + f];
    end
    return r;
  endfunction

  assign req   = read || write;
  assign wr_go = clk_en && write && !waitrequest;
  assign {wr_ism, wr_idx} = match_dec(address);
  assign {rd_ism, rd_idx} = match_dec(address);
  assign mact_wd = be_merge(32'(mact), writedata, byteenable);

  // Counter advances once per prescaler wrap
  assign tick = clk_en && cnt_en && !cnt_rst && (pcnt == pre);

  // Comparators on the working match values
  always_comb begin
    for (int i = 0; i < MPW_NMATCH; i++) begin
      match[i] = tick && (count == active[i]);
    end
  end

  assign int_mask  = mact_field(mact, MPW_MACT_INT);
  assign stop_mask = mact_field(mact, MPW_MACT_STOP);
  // Pulse mode forces match zero to close the cycle
  assign rst_mask  = mact_field(mact, MPW_MACT_RESET) | {6'h00, pwm_mode};
  assign any_reset = |(match & rst_mask);
  assign any_stop  = |(match & stop_mask);
  assign cycle_end = match[0] && pwm_mode;

  // Control readback image
  always_comb begin
    ctrl_rd               = MPW_ZERO32;
    ctrl_rd[MPW_CTRL_EN]  = cnt_en;
    ctrl_rd[MPW_CTRL_RST] = cnt_rst;
    ctrl_rd[MPW_CTRL_PWM] = pwm_mode;
  end

  // Bus handshake: one wait cycle, then the answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else if (clk_en) begin
      waitrequest <= !(req && waitrequest);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= MPW_ZERO32;
    end else if (clk_en && read && waitrequest) begin
      case (address)
        MPW_OFS_CTRL:  readdata <= ctrl_rd;
        MPW_OFS_COUNT: readdata <= count;
        MPW_OFS_PRE:   readdata <= pre;
        MPW_OFS_PCNT:  readdata <= pcnt;
        MPW_OFS_MACT:  readdata <= 32'(mact);
        MPW_OFS_FLAG:  readdata <= 32'(flag);
        MPW_OFS_OCFG:  readdata <= 32'({out_ena, 2'b00, dbl_sel, 1'b0});
        MPW_OFS_REL:   readdata <= 32'(rel);
        default:       readdata <= rd_ism ? shadow[rd_idx] : MPW_ZERO32;
      endcase
    end
  end

  // Control and configuration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_en   <= 1'b0;
      cnt_rst  <= 1'b0;
      pwm_mode <= 1'b0;
      mact     <= 21'h00000;
      pre      <= MPW_ZERO32;
      dbl_sel  <= 6'h00;
      out_ena  <= 6'h00;
    end else if (clk_en) begin
      if (wr_go && address == MPW_OFS_CTRL && byteenable[0]) begin
        cnt_en   <= writedata[MPW_CTRL_EN];
        cnt_rst  <= writedata[MPW_CTRL_RST];
        pwm_mode <= writedata[MPW_CTRL_PWM];
      end else if (any_stop) begin
        cnt_en <= 1'b0;
      end
      if (wr_go && address == MPW_OFS_MACT) begin
        mact <= mact_wd[MPW_MACT_BITS-1:0];
      end
      if (wr_go && address == MPW_OFS_PRE) begin
        pre <= be_merge(pre, writedata, byteenable);
      end
      if (wr_go && address == MPW_OFS_OCFG && byteenable[0]) begin
        dbl_sel <= {writedata[MPW_OCFG_SEL + 1 +: MPW_NOUT - 1], 1'b0};
      end
      if (wr_go && address == MPW_OFS_OCFG && byteenable[1]) begin
        out_ena <= writedata[MPW_OCFG_ENA +: MPW_NOUT];
      end
    end
  end

  // Prescaler
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcnt <= MPW_ZERO32;
    end else if (clk_en) begin
      if (cnt_rst) begin
        pcnt <= MPW_ZERO32;
      end else if (wr_go && address == MPW_OFS_PCNT) begin
        pcnt <= be_merge(pcnt, writedata, byteenable);
      end else if (cnt_en) begin
        pcnt <= (pcnt == pre) ? MPW_ZERO32 : pcnt + MPW_ONE32;
      end
    end
  end

  // Counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= MPW_ZERO32;
    end else if (clk_en) begin
      if (cnt_rst) begin
        count <= MPW_ZERO32;
      end else if (wr_go && address == MPW_OFS_COUNT) begin
        count <= be_merge(count, writedata, byteenable);
      end else if (tick) begin
        count <= any_reset ? MPW_ZERO32 : count + MPW_ONE32;
      end
    end
  end

  // Match flags: set by hardware, cleared by writing one; set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag <= 7'h00;
    end else if (clk_en) begin
      for (int i = 0; i < MPW_NMATCH; i++) begin
        if (match[i] && int_mask[i]) begin
          flag[i] <= 1'b1;
        end else if (wr_go && address == MPW_OFS_FLAG && byteenable[0]
                     && writedata[i]) begin
          flag[i] <= 1'b0;
        end
      end
    end
  end

  // Release bits: software sets, cycle boundary consumes; set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rel <= 7'h00;
    end else if (clk_en) begin
      for (int i = 0; i < MPW_NMATCH; i++) begin
        if (wr_go && address == MPW_OFS_REL && byteenable[0]
            && writedata[i]) begin
          rel[i] <= 1'b1;
        end else if (cycle_end) begin
          rel[i] <= 1'b0;
        end
      end
    end
  end

  // Shadow values take bus writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MPW_NMATCH; i++) begin
        shadow[i] <= MPW_ZERO32;
      end
    end else if (clk_en && wr_go && wr_ism) begin
      shadow[wr_idx] <= be_merge(shadow[wr_idx], writedata, byteenable);
    end
  end

  // Working values: direct in timer mode, released copies in pulse mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MPW_NMATCH; i++) begin
        active[i] <= MPW_ZERO32;
      end
    end else if (clk_en) begin
      for (int i = 0; i < MPW_NMATCH; i++) begin
        if (!pwm_mode) begin
          active[i] <= shadow[i];
        end else if (cycle_end && rel[i]) begin
          active[i] <= shadow[i];
        end
      end
    end
  end

  // Channel n uses match n; double edge rises on match n-1
  for (genvar n = 1; n <= MPW_NOUT; n++) begin : g_chan
    mpw_chan u_chan (
      .clk        (clk),
      .rst        (rst),
      .clk_en     (clk_en),
      .enable     (pwm_mode && out_ena[n]),
      .dbl        (dbl_sel[n]),
      .cyc_match  (match[0]),
      .rise_match (match[n-1]),
      .fall_match (match[n]),
      .pwm_out    (pwm_out[n])
    );
  end

  sequence s_release;
    rel[2] && cycle_end && !wr_go;
  endsequence

  sequence s_pend;
    rel[2] && pwm_mode && !cycle_end;
  endsequence

  sequence s_pre_step;
    clk_en && cnt_en && !cnt_rst && (pcnt != pre) && !wr_go;
  endsequence

  chk_count_hold: assert property (@(posedge clk) disable iff (rst)
    (!tick && !cnt_rst && !wr_go) |=> count == $past(count))
    else $error("counter moved without a prescaler wrap");
  chk_cycle_reset: assert property (@(posedge clk) disable iff (rst)
    (cycle_end && !cnt_rst && !wr_go) |=> count == MPW_ZERO32)
    else $error("counter not cleared by cycle match");
  chk_match_stop: assert property (@(posedge clk) disable iff (rst)
    (any_stop && !wr_go) |=> !cnt_en) else $error("counter kept running after stop match");
  chk_match_flag: assert property (@(posedge clk) disable iff (rst)
    (match[1] && int_mask[1]) |=> flag[1]) else $error("match flag not set");
  chk_release_apply: assert property (@(posedge clk) disable iff (rst)
    s_release |=> (active[2] == $past(shadow[2])) && !rel[2])
    else $error("released value not applied at cycle end");
  chk_release_wait: assert property (@(posedge clk) disable iff (rst)
    (s_pend ##0 clk_en) |=> active[2] == $past(active[2]))
    else $error("match value changed before cycle end");
  chk_timer_quiet: assert property (@(posedge clk) disable iff (rst)
    (!pwm_mode && clk_en) [*2] |-> pwm_out == 6'h00)
    else $error("pulse output active in timer mode");
  chk_reset_state: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> count == MPW_ZERO32 && !pwm_mode && pwm_out == 6'h00)
    else $error("state not cleared by reset");
  chk_bus_answer: assert property (@(posedge clk) disable iff (rst)
    (clk_en && req && waitrequest) |=> !waitrequest)
    else $error("bus answer missing");
  chk_bus_idle: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !req) |=> waitrequest)
    else $error("bus answered without a request");
  chk_pre_step: assert property (@(posedge clk) disable iff (rst)
    s_pre_step |=> pcnt == $past(pcnt) + MPW_ONE32)
    else $error("prescaler did not advance");
  chk_shadow_track: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !pwm_mode) |=> active[1] == $past(shadow[1]))
    else $error("timer mode match value not taken");
  chk_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    (flag[1] && !wr_go) |=> flag[1])
    else $error("match flag lost without a clear");
  chk_rel_hold: assert property (@(posedge clk) disable iff (rst)
    (rel[2] && !cycle_end) |=> rel[2])
    else $error("release dropped before cycle end");
endmodule

// ### mpw_load.sv
// Load model for the six pulse outputs: measures high time and period.
// Assumes the outputs are level signals sampled on the rising clock edge.
`timescale 1ns/1ns
module mpw_load
  import mpw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [6:1]  pwm_out,
  output logic [6:1][15:0] hi_len,
  output logic [6:1][15:0] per_len
);
  logic [6:1]       prev;
  logic [6:1][15:0] hi_cnt;
  logic [6:1][15:0] per_cnt;

  // Length of the last complete high phase and of the last rise-to-rise span
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev    <= '0;
      hi_cnt  <= '0;
      per_cnt <= '0;
      hi_len  <= '0;
      per_len <= '0;
    end else begin
      prev <= pwm_out;
      for (int k = 1; k <= 6; k++) begin
        hi_cnt[k]  <= pwm_out[k] ? hi_cnt[k] + 16'h0001 : 16'h0000;
        per_cnt[k] <= (pwm_out[k] && !prev[k]) ? 16'h0001 : per_cnt[k] + 16'h0001;
        if (!pwm_out[k] && prev[k]) begin
          hi_len[k] <= hi_cnt[k];
        end
        if (pwm_out[k] && !prev[k]) begin
          per_len[k] <= per_cnt[k];
        end
      end
    end
  end
endmodule

// ### tb_mpw_timer.sv
// Self-checking bench for the match based pulse width timer.
// Assumes the Avalon-MM register map of the package and a 100 MHz clock.
`timescale 1ns/1ns
module tb_mpw_timer;
  import mpw_pkg::*;
  logic             clk         = 1'b0;
  logic             rst         = 1'b1;
  logic             clk_en      = 1'b1;
  logic             read        = 1'b0;
  logic             write       = 1'b0;
  logic [5:0]       address     = 6'h00;
  logic [31:0]      writedata   = 32'h0000_0000;
  logic [3:0]       byteenable  = 4'hF;
  logic [31:0]      readdata;
  logic             waitrequest;
  logic [6:1]       pwm_out;
  logic [6:1][15:0] hi_len;
  logic [6:1][15:0] per_len;
  logic [31:0]      mr [7];
  logic [15:0]      eh [7];
  int               n_mismatch  = 0;
  int               num_checks  = 0;

  always #5 clk = ~clk;

  mpw_timer mpw_timer_inst (
    .clk         (clk),
    .rst         (rst),
    .clk_en      (clk_en),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .byteenable  (byteenable),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .pwm_out     (pwm_out)
  );

  mpw_load mpw_load_inst (
    .clk     (clk),
    .rst     (rst),
    .pwm_out (pwm_out),
    .hi_len  (hi_len),
    .per_len (per_len)
  );

  task automatic complete_run();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon-MM access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask

  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    mr = '{32'h9, 32'h9, 32'h3, 32'h6, 32'h2, 32'h1, 32'h7};
    eh = '{16'h0, 16'h0, 16'h4, 16'h7, 16'h6, 16'h2, 16'h6};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(MPW_OFS_CTRL, MPW_ZERO32);
    rd(MPW_OFS_COUNT, MPW_ZERO32);
    rd(MPW_OFS_PCNT, MPW_ZERO32);
    rd(MPW_OFS_MACT, MPW_ZERO32);
    check({26'h0, pwm_out}, MPW_ZERO32);
    rd(6'h3C, MPW_ZERO32);
    // Plain timer: stop with flag on match one
    wr(MPW_OFS_PRE, MPW_ONE32);
    wr(MPW_OFS_MBASE + 6'h04, 32'h0000_0005);
    wr(MPW_OFS_MACT, 32'h0000_0028);
    wr(MPW_OFS_CTRL, MPW_ONE32);
    repeat (40) @(posedge clk);
    rd(MPW_OFS_CTRL, MPW_ZERO32);
    rd(MPW_OFS_FLAG, 32'h0000_0002);
    wr(MPW_OFS_FLAG, 32'h0000_0002);
    rd(MPW_OFS_FLAG, MPW_ZERO32);
    // Pulse mode with mixed single and double edge outputs
    wr(MPW_OFS_PRE, MPW_ZERO32);
    wr(MPW_OFS_MACT, MPW_ZERO32);
    wr(MPW_OFS_COUNT, MPW_ZERO32);
    wr(MPW_OFS_PCNT, MPW_ZERO32);
    for (int i = 0; i < 7; i++) begin
      wr(MPW_OFS_MBASE + 6'(4 * i), mr[i]);
    end
    wr(MPW_OFS_OCFG, 32'h0000_7E50);
    wr(MPW_OFS_CTRL, 32'h0000_0009);
    repeat (60) @(posedge clk);
    check(hi_len[1], MPW_ZERO32);
    check(per_len[1], MPW_ZERO32);
    for (int k = 2; k <= 6; k++) begin
      check(per_len[k], 32'h0000_000A);
      check(hi_len[k], eh[k]);
    end
    // New value stays in shadow until released
    wr(MPW_OFS_MBASE + 6'h08, 32'h0000_0005);
    repeat (40) @(posedge clk);
    check(hi_len[2], 32'h0000_0004);
    wr(MPW_OFS_REL, 32'h0000_0004);
    repeat (40) @(posedge clk);
    check(hi_len[2], 32'h0000_0006);
    rd(MPW_OFS_REL, MPW_ZERO32);
    // Prescaler doubles every span
    wr(MPW_OFS_PRE, MPW_ONE32);
    repeat (80) @(posedge clk);
    check(per_len[2], 32'h0000_0014);
    check(hi_len[2], 32'h0000_000C);
    // Leaving pulse mode silences the outputs
    wr(MPW_OFS_CTRL, MPW_ONE32);
    repeat (30) @(posedge clk);
    check({26'h0, pwm_out}, MPW_ZERO32);
    // Clock enable low freezes the counter
    wr(MPW_OFS_CTRL, 32'h0000_0002);
    wr(MPW_OFS_CTRL, MPW_ONE32);
    clk_en <= 1'b0;
    repeat (10) @(posedge clk);
    clk_en <= 1'b1;
    rd(MPW_OFS_COUNT, MPW_ZERO32);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(MPW_OFS_CTRL, MPW_ZERO32);
    rd(MPW_OFS_OCFG, MPW_ZERO32);
    complete_run();
  end
endmodule
